/* itx_pkg.sv */
// Purpose: Constants for the isochronous transmit context status and control block.
// Assumes: One clock domain, Avalon-MM register access, eight transmit contexts.
// Notes: Offsets are byte addresses; each register takes one 32-bit word.
// Operation
// - Control bits 14..13 and 9..8 read as zero and ignore writes.
// - The block clears the wake bit on every descriptor fetch taken while fetch is enabled.
// - The block sets the dead bit 11 when the context meets a fatal error.
// - The dead bit clears only when software clears run bit 15.
// - The active bit 10 is one while the context processes descriptors.
// - The speed field 7..5 has no meaning for transmit and software must not rely on it.
// - After a last-output command the event field 4..0 takes the completion or error code.
// - On a transmit overflow each running context tolerates up to seven skipped cycles.
// - Skip handling runs only with dead set, event equal to timeout and the fatal fault flag set.
// - The descriptor pointer holds the last descriptor block address fetched while fetch is enabled.
// - The descriptor pointer can be read while the context is active, showing the current position.
// - Each of eight contexts has a read-only pointer at 20Ch plus sixteen times the context number.
// - Software sets run to start and clears it to stop; the block changes run only on reset.
// - Control is written through a set alias at 200h and a clear alias at 204h plus sixteen times n.
//------------------------------------------------------------------------------
// Package
//------------------------------------------------------------------------------
package itx_pkg;
    localparam int ITX_CTX_NUM = 8;
    localparam logic [11:0] ITX_CTL_SET_BASE = 12'h200;
    localparam logic [11:0] ITX_CTL_CLR_BASE = 12'h204;
    localparam logic [11:0] ITX_PTR_BASE = 12'h20C;
    localparam logic [11:0] ITX_CTX_STRIDE = 12'h010;
    localparam logic [11:0] ITX_INT_STAT = 12'h300;
    localparam logic [11:0] ITX_INT_MASK = 12'h304;
    localparam logic [11:0] ITX_SKIP_STAT = 12'h308;
    localparam int ITX_RUN_BIT = 15;
    localparam int ITX_WAKE_BIT = 12;
    localparam int ITX_DEAD_BIT = 11;
    localparam int ITX_ACTIVE_BIT = 10;
    localparam int ITX_EVT_LSB = 0;
    localparam logic [31:0] ITX_CTL_WMASK = 32'h0000_9000;
    localparam logic [4:0] ITX_EVT_TIMEOUT = 5'h0A;
    localparam logic [4:0] ITX_EVT_UNKNOWN = 5'h0E;
    localparam logic [4:0] ITX_EVT_DESC_READ = 5'h05;
    localparam logic [4:0] ITX_EVT_DATA_READ = 5'h07;
    localparam logic [4:0] ITX_EVT_ACK_COMPLETE = 5'h11;
    localparam logic [2:0] ITX_SKIP_MAX = 3'h7;
    localparam logic [4:0] ITX_EVT_RESET = 5'h00;
    typedef enum logic [1:0] {ITX_ST_IDLE, ITX_ST_RUN, ITX_ST_DEAD} itx_state_e;
endpackage : itx_pkg

/* itx_context_status.sv */
// Purpose: Status and control of eight isochronous transmit DMA contexts.
// Assumes: Fetch engine and transmitter drive the per-context event inputs.
// Notes: Register access over Avalon-MM; answers come one cycle after request.
//
// Added by the designer: the Avalon-MM slave port.
module itx_context_status
    import itx_pkg::*;
#(
    parameter int CTX = ITX_CTX_NUM
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Fetch engine and transmitter
    input wire logic [CTX-1:0] desc_fetch,
    input wire logic [CTX*32-1:0] desc_addr,
    input wire logic [CTX-1:0] fatal_err,
    input wire logic [CTX-1:0] last_done,
    input wire logic [CTX*5-1:0] last_evt,
    input wire logic [CTX-1:0] desc_end,
    input wire logic [CTX-1:0] tx_overflow,
    input wire logic fatal_fault_flag,
    // Context control outputs
    output logic [CTX-1:0] ctx_run,
    output logic [CTX-1:0] ctx_wake,
    output logic [CTX-1:0] fetch_enable,
    output logic [CTX-1:0] ctx_active,
    output logic [CTX-1:0] skip_cycle,
    // Interrupt
    output logic irq
);

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    typedef struct packed {
        itx_state_e [CTX-1:0] st;
        logic [CTX-1:0] run;
        logic [CTX-1:0] wake;
        logic [CTX-1:0] dead;
        logic [CTX-1:0][4:0] evt;
        logic [CTX-1:0][31:0] ptr;
        logic [CTX-1:0][2:0] skips;
        logic [CTX-1:0] skip;
        logic [CTX-1:0] dead_sts;
        logic [CTX-1:0] done_sts;
        logic [CTX-1:0] dead_msk;
        logic [CTX-1:0] done_msk;
        logic [31:0] rdata;
        logic ack;
    } itx_state_s;

    itx_state_s cur;
    itx_state_s next_cur;

    // True when the address hits the word of context n at this base.
    function automatic logic ctx_hit(input logic [11:0] a, input logic [11:0] base, input int n);
        return a == base + 12'(n) * ITX_CTX_STRIDE;
    endfunction

    logic req;
    logic wr_acc;
    assign req = (avs_read | avs_write) & ~cur.ack;
    // Writes land at the edge where waitrequest is seen low, so a master that holds its request sees one effect.
    assign wr_acc = avs_write & cur.ack;

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------
    always_comb begin
        logic [31:0] ctl;
        logic [31:0] wd;
        ctl = 32'h0000_0000;
        wd = avs_writedata;
        next_cur = cur;
        next_cur.ack = req;
        next_cur.rdata = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (!avs_byteenable[b]) begin
                wd[b*8 +: 8] = 8'h00;
            end
        end
        for (int n = 0; n < CTX; n++) begin
            // Spd bits 7..5 are never driven, so they read zero.
            ctl = 32'h0000_0000;
            ctl[ITX_RUN_BIT] = cur.run[n];
            ctl[ITX_WAKE_BIT] = cur.wake[n];
            ctl[ITX_DEAD_BIT] = cur.dead[n];
            ctl[ITX_ACTIVE_BIT] = (cur.st[n] == ITX_ST_RUN);
            ctl[ITX_EVT_LSB +: 5] = cur.evt[n]; // bits 14..13, 9..8 stay zero
            if (req && avs_read) begin
                if (ctx_hit(avs_address, ITX_CTL_SET_BASE, n) || ctx_hit(avs_address, ITX_CTL_CLR_BASE, n)) begin
                    next_cur.rdata = ctl;
                end
                if (ctx_hit(avs_address, ITX_PTR_BASE, n)) begin
                    next_cur.rdata = cur.ptr[n];
                end
            end
            // Only run and wake are writable; set alias ORs both, clear alias masks run only.
            if (wr_acc && ctx_hit(avs_address, ITX_CTL_SET_BASE, n)) begin
                next_cur.run[n] = cur.run[n] | wd[ITX_RUN_BIT];
                next_cur.wake[n] = cur.wake[n] | wd[ITX_WAKE_BIT];
            end
            if (wr_acc && ctx_hit(avs_address, ITX_CTL_CLR_BASE, n)) begin
                next_cur.run[n] = cur.run[n] & ~wd[ITX_RUN_BIT];
            end
            if (desc_fetch[n] && fetch_enable[n]) begin
                next_cur.wake[n] = 1'b0;
                next_cur.ptr[n] = desc_addr[n*32 +: 32];
            end
            next_cur.skip[n] = 1'b0;
            case (cur.st[n])
                ITX_ST_IDLE: begin
                    // A stopped context starts on the run write; a drained one waits for wake.
                    if (next_cur.run[n] && (!cur.run[n] || cur.wake[n])) begin
                        next_cur.st[n] = ITX_ST_RUN;
                        if (!cur.run[n]) begin
                            next_cur.skips[n] = 3'h0;
                        end
                    end
                end
                ITX_ST_RUN: begin
                    if (!cur.run[n]) begin
                        next_cur.st[n] = ITX_ST_IDLE;
                    end else if (fatal_err[n]) begin
                        next_cur.st[n] = ITX_ST_DEAD;
                        next_cur.dead[n] = 1'b1;
                        next_cur.dead_sts[n] = 1'b1;
                    end else if (desc_end[n] && !cur.wake[n]) begin
                        next_cur.st[n] = ITX_ST_IDLE;
                    end
                    if (last_done[n] && !fatal_err[n]) begin
                        next_cur.evt[n] = last_evt[n*5 +: 5];
                        next_cur.done_sts[n] = 1'b1;
                    end
                end
                ITX_ST_DEAD: begin
                    if (!cur.run[n]) begin
                        next_cur.st[n] = ITX_ST_IDLE;
                        next_cur.dead[n] = 1'b0;
                    end
                end
                default: begin
                    next_cur.st[n] = ITX_ST_IDLE;
                end
            endcase
            // Cycle skip: bounded to seven so a stuck overflow cannot loop forever.
            if (cur.run[n] && tx_overflow[n] && cur.dead[n] && cur.evt[n] == ITX_EVT_TIMEOUT
                && fatal_fault_flag && cur.skips[n] != ITX_SKIP_MAX) begin
                next_cur.skip[n] = 1'b1;
                next_cur.skips[n] = cur.skips[n] + 3'h1;
            end
        end
        // Interrupt status: write one clears; a new event in the same cycle survives only if its bit was clear.
        if (wr_acc && avs_address == ITX_INT_STAT) begin
            next_cur.dead_sts = (cur.dead_sts & ~wd[CTX-1:0]) | (next_cur.dead_sts & ~cur.dead_sts);
            next_cur.done_sts = (cur.done_sts & ~wd[16 +: CTX]) | (next_cur.done_sts & ~cur.done_sts);
        end
        if (wr_acc && avs_address == ITX_INT_MASK) begin
            next_cur.dead_msk = wd[CTX-1:0];
            next_cur.done_msk = wd[16 +: CTX];
        end
        if (req && avs_read) begin
            if (avs_address == ITX_INT_STAT) begin
                next_cur.rdata = 32'h0000_0000;
                next_cur.rdata[CTX-1:0] = cur.dead_sts;
                next_cur.rdata[16 +: CTX] = cur.done_sts;
            end
            if (avs_address == ITX_INT_MASK) begin
                next_cur.rdata = 32'h0000_0000;
                next_cur.rdata[CTX-1:0] = cur.dead_msk;
                next_cur.rdata[16 +: CTX] = cur.done_msk;
            end
            if (avs_address == ITX_SKIP_STAT) begin
                next_cur.rdata = 32'h0000_0000;
                for (int n = 0; n < CTX; n++) begin
                    next_cur.rdata[n*4 +: 3] = cur.skips[n];
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < CTX; n++) begin
            ctx_active[n] = (cur.st[n] == ITX_ST_RUN);
            fetch_enable[n] = (cur.st[n] == ITX_ST_RUN) | (cur.run[n] & cur.st[n] == ITX_ST_IDLE & cur.wake[n]);
        end
    end

    assign ctx_run = cur.run;
    assign ctx_wake = cur.wake;
    assign skip_cycle = cur.skip;
    assign avs_readdata = cur.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~cur.ack;
    assign irq = |((cur.dead_sts & cur.dead_msk) | (cur.done_sts & cur.done_msk));

endmodule // itx_context_status

/* itx_props.sv */
// Purpose: Port-level checks for the transmit context status block.
// Assumes: Bound to the block; one clock domain, synchronous reset.
// Notes: Dead is internal, so it is judged through run, active and fetch enable.
module itx_props
    import itx_pkg::*;
#(
    parameter int CTX = ITX_CTX_NUM
) (
    // Clock, reset and bus
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Context side
    input wire logic [CTX-1:0] desc_fetch,
    input wire logic [CTX-1:0] fatal_err,
    input wire logic [CTX-1:0] tx_overflow,
    input wire logic fatal_fault_flag,
    input wire logic [CTX-1:0] ctx_run,
    input wire logic [CTX-1:0] ctx_wake,
    input wire logic [CTX-1:0] fetch_enable,
    input wire logic [CTX-1:0] ctx_active,
    input wire logic [CTX-1:0] skip_cycle,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_answer_one_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not one cycle late");
    a_run_by_write: assert property (ctx_run != $past(ctx_run) |-> $past(avs_write && !avs_waitrequest))
        else $error("run changed without a write");
    // Active or fetch without run may only linger for the cycle after a clear.
    a_active_needs_run: assert property ((ctx_active & ~ctx_run) != '0 |-> $past(avs_write && !avs_waitrequest))
        else $error("active without run");
    a_fetch_needs_run: assert property ((fetch_enable & ~ctx_run) != '0 |-> $past(avs_write && !avs_waitrequest))
        else $error("fetch enabled without run");
    a_wake_by_fetch: assert property (($past(ctx_wake) & ~ctx_wake & ~$past(desc_fetch & fetch_enable)) == '0)
        else $error("wake cleared without fetch");
    a_dead_stops: assert property ((fatal_err & ctx_run) != '0 |=> ((fetch_enable | ctx_active) & $past(fatal_err)) == '0)
        else $error("context still working after fatal error");
    a_skip_cause: assert property ((skip_cycle & ~$past(tx_overflow & ctx_run & {CTX{fatal_fault_flag}})) == '0)
        else $error("skip without its conditions");
    a_rsvd_zero: assert property (avs_read && !avs_waitrequest && avs_address[11:7] == 5'h04 && !avs_address[3]
        |-> (avs_readdata & 32'h0000_6300) == '0)
        else $error("reserved control bits not zero");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && ctx_run == '0 && ctx_wake == '0)
        else $error("state not cleared by reset");
endmodule // itx_props

bind itx_context_status itx_props #(.CTX(CTX)) i_itx_props (.clk_sys, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .desc_fetch, .fatal_err, .tx_overflow, .fatal_fault_flag,
    .ctx_run, .ctx_wake, .fetch_enable, .ctx_active, .skip_cycle, .irq);

/* itx_mem_model.sv */
// Purpose: Descriptor fetch engine and memory standing behind the block.
// Assumes: A fetch is offered one to GAP cycles after the block enables it; the block ignores it once enable drops.
// Notes: GAP spaces fetches apart to mimic slow memory.
module itx_mem_model #(
    parameter int CTX = 8,
    parameter int GAP = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [CTX-1:0] fetch_enable,
    output logic [CTX-1:0] desc_fetch,
    output logic [CTX*32-1:0] desc_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge clk_sys) begin
        cnt <= (sys_rst || cnt >= GAP - 1) ? 0 : cnt + 1;
        desc_fetch <= (sys_rst || cnt != 0) ? '0 : fetch_enable & ~desc_fetch;
    end
    for (genvar n = 0; n < CTX; n++) begin : g_addr
        assign desc_addr[n*32 +: 32] = 32'h0001_0000 + 32'(n * 64);
    end
endmodule // itx_mem_model

/* itx_context_status_tb_top.sv */
// Purpose: Self-checking bench for the transmit context status block.
// Assumes: Context 2 carries the traffic; the other contexts stay idle.
// Notes: Reads queue their expectation; a monitor compares at the answer edge.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module itx_context_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import itx_pkg::*;
    localparam logic [11:0] OFS = 12'h020;
    localparam logic [7:0] M = 8'h04;
    logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, fatal_fault_flag = 0, avs_waitrequest, irq;
    logic [11:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rnd, e;
    logic [7:0] fatal_err = 0, last_done = 0, desc_end = 0, tx_overflow = 0;
    logic [7:0] desc_fetch, ctx_run, ctx_wake, fetch_enable, ctx_active, skip_cycle;
    logic [255:0] desc_addr;
    logic [39:0] last_evt = 0;
    logic [4:0] codes [5] = '{ITX_EVT_ACK_COMPLETE, ITX_EVT_DESC_READ, ITX_EVT_DATA_READ, ITX_EVT_UNKNOWN, ITX_EVT_TIMEOUT};
    logic [31:0] exp_q [$];
    int num_errors = 0, n_checks = 0, cyc = 0, seed = 41139, skips = 0;
    itx_context_status #(.CTX(8)) i_itx_context_status (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .desc_fetch, .desc_addr, .fatal_err,
        .last_done, .last_evt, .desc_end, .tx_overflow, .fatal_fault_flag, .ctx_run, .ctx_wake, .fetch_enable,
        .ctx_active, .skip_cycle, .irq);
    itx_mem_model #(.CTX(8), .GAP(3)) i_itx_mem_model (.clk_sys, .sys_rst, .fetch_enable, .desc_fetch, .desc_addr);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic end_sim();
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end else if (avs_read && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            `CHK(avs_readdata, e)
        end
    end
    // One cycle of idle between requests keeps each signal to one update per step.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic hit(input logic [7:0] ld, input logic [7:0] fe, input logic [7:0] de, input logic [4:0] code);
        last_done <= ld;
        fatal_err <= fe;
        desc_end <= de;
        last_evt[10 +: 5] <= code;
        @(posedge clk_sys);
        last_done <= 8'h00;
        fatal_err <= 8'h00;
        desc_end <= 8'h00;
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int n = 0; n < 8; n++) begin
            rd(ITX_CTL_SET_BASE + 12'(n * 16), 32'h0);
            rd(ITX_PTR_BASE + 12'(n * 16), 32'h0);
        end
        rd(12'h3FC, 32'h0);
        rnd = $random(seed);
        bus(1'b1, ITX_CTL_SET_BASE + OFS, rnd | 32'h8000);
        repeat (8) @(posedge clk_sys);
        rd(ITX_CTL_CLR_BASE + OFS, 32'h8400);
        rd(ITX_PTR_BASE + OFS, 32'h0001_0080);
        `CHK(ctx_run, M)
        `CHK(ctx_active, M)
        hit(8'h00, 8'h00, M, 5'h00);
        rd(ITX_CTL_SET_BASE + OFS, 32'h8000);
        `CHK(ctx_active, 8'h00)
        bus(1'b1, ITX_CTL_SET_BASE + OFS, 32'h1000);
        repeat (8) @(posedge clk_sys);
        rd(ITX_CTL_SET_BASE + OFS, 32'h8400);
        `CHK(ctx_wake, 8'h00)
        for (int i = 0; i < 5; i++) begin
            hit(M, 8'h00, 8'h00, codes[i]);
            rd(ITX_CTL_SET_BASE + OFS, 32'h8400 | 32'(codes[i]));
        end
        hit(8'h00, M, 8'h00, 5'h00);
        rd(ITX_CTL_SET_BASE + OFS, 32'h880A);
        `CHK(fetch_enable, 8'h00)
        rd(ITX_INT_STAT, 32'h0004_0004);
        `CHK(irq, 1'b0)
        bus(1'b1, ITX_INT_MASK, 32'h0000_0004);
        `CHK(irq, 1'b1)
        fatal_fault_flag <= 1'b1;
        tx_overflow <= M;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            skips += skip_cycle[2];
        end
        `CHK(skips, 7)
        tx_overflow <= 8'h00;
        fatal_fault_flag <= 1'b0;
        @(posedge clk_sys);
        rd(ITX_SKIP_STAT, 32'h0000_0700);
        bus(1'b1, ITX_CTL_CLR_BASE + OFS, 32'h8000);
        rd(ITX_CTL_SET_BASE + OFS, 32'h0000_000A);
        bus(1'b1, ITX_INT_STAT, 32'h0004_0004);
        `CHK(irq, 1'b0)
        end_sim();
    end
endmodule // itx_context_status_tb_top
